// file: rtl/rtu_pkg.sv
// package: constants for the rtu slave framer
package rtu_pkg;
   localparam int          CLK_HZ        = 40_000_000;
   localparam int          BAUD_DEFAULT  = 9600;
   localparam int          BITS_PER_CHAR = 11;
   // gaps in tenths of a character time
   localparam int          GAP_END_X10   = 35;
   localparam int          GAP_ABORT_X10 = 15;
   localparam logic [7:0]  ADDR_BCAST    = 8'h00;
   localparam logic [7:0]  ADDR_MAX      = 8'hF7;
   localparam logic [7:0]  CMD_READ      = 8'h03;
   localparam logic [7:0]  CMD_WRITE     = 8'h06;
   localparam logic [7:0]  EXC_FLAG      = 8'h80;
   localparam logic [7:0]  EXC_ILL_FUNC  = 8'h01;
   localparam logic [7:0]  EXC_ILL_DATA  = 8'h03;
   localparam logic [7:0]  EXC_DEV_FAIL  = 8'h04;
   localparam logic [15:0] READ_MAX      = 16'h000C;
   localparam logic [15:0] CRC_INIT      = 16'hFFFF;
   localparam logic [15:0] CRC_POLY      = 16'hA001;
   localparam logic [3:0]  REQ_LEN       = 4'h8;
   localparam int          BUF_DEPTH     = 8;
   localparam logic [31:0] TIMER_MAX     = 32'hFFFF_FFFF;
endpackage

// file: rtl/rtu_crc.sv
// module: one-cycle byte update of the frame check register
`timescale 1ns/1ps
module rtu_crc
   import rtu_pkg::*;
(
   input  wire logic [15:0] crc_in,
   input  wire logic [7:0]  data,
   output logic      [15:0] crc_out
);
   // eight shift steps unrolled by the loop; data bits only, no framing bits
   always_comb begin
      logic [15:0] c;
      c = crc_in ^ {8'h00, data};
      for (int i = 0; i < 8; i++) begin
         c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
      end
      crc_out = c;
   end
endmodule

// file: rtl/rtu_slave_framer.sv
// module: modbus rtu slave frame handler, receive, check, decode and reply
`timescale 1ns/1ps
module rtu_slave_framer
   import rtu_pkg::*;
#(
   parameter int BAUD = BAUD_DEFAULT
)(
   input  wire logic        CLOCK,
   input  wire logic        RESETN,
   input  wire logic [7:0]  STATION_ADDR,
   input  wire logic        REPLY_COUNT_WIDTH_SELECT,
   input  wire logic [7:0]  RX_DATA,
   input  wire logic        RX_VALID,
   output logic      [7:0]  TX_DATA,
   output logic             TX_VALID,
   input  wire logic        TX_READY,
   output logic             TX_ENABLE,
   output logic             REQ_VALID,
   output logic             REQ_WRITE,
   output logic      [15:0] REQ_ADDR,
   output logic      [15:0] REQ_WDATA,
   input  wire logic        REQ_ACK,
   input  wire logic        REQ_FAIL,
   input  wire logic [15:0] REQ_RDATA,
   output logic             CHECK_ERROR
);
   // ------------------------------------------------------------
   // timing
   // ------------------------------------------------------------
   localparam int CHAR_CYC  = (CLK_HZ / BAUD) * BITS_PER_CHAR;
   localparam int END_CYC   = (CHAR_CYC * GAP_END_X10 + 9) / 10;   // least time, round up
   localparam int ABORT_CYC = (CHAR_CYC * GAP_ABORT_X10 + 9) / 10;

   typedef enum logic [2:0] {
      S_IDLE  = 3'b000,   // waiting for a 3.5 character silence
      S_RECV  = 3'b001,
      S_DONE  = 3'b010,   // frame closed, evaluate
      S_ACCES = 3'b011,   // parameter access in progress
      S_SEND  = 3'b100,
      S_GAP   = 3'b101    // hold silence before our reply
   } state_t;

   typedef struct packed {
      state_t      st;
      logic [31:0] idle;
      logic        synced;
      logic        broken;
      logic [3:0]  len;
      logic [7:0]  buf0, buf1, buf2, buf3, buf4, buf5, buf6, buf7;
      logic [15:0] crc;
      logic [4:0]  widx;      // word index during a read
      logic [5:0]  tidx;      // transmit byte index
      logic [15:0] tcrc;
      logic        exc;
      logic [7:0]  exc_code;
      logic [7:0]  tx_data;
      logic        tx_valid;
      logic        tx_en;
      logic        req_valid;
      logic        req_write;
      logic [15:0] req_addr;
      logic [15:0] req_wdata;
      logic        chk_err;
      logic        bcast;
   } regs_t;

   regs_t r, next_r;
   logic [7:0]  tx_next_byte;
   logic [15:0] crc_next;
   logic [15:0] tx_crc_next;
   logic [7:0]  tx_byte;

   // helpers
   function automatic logic [7:0] pick(input regs_t s, input logic [2:0] i);
      logic [7:0] v;
      v = 8'h00;
      unique case (i)
         3'd0: v = s.buf0;
         3'd1: v = s.buf1;
         3'd2: v = s.buf2;
         3'd3: v = s.buf3;
         3'd4: v = s.buf4;
         3'd5: v = s.buf5;
         3'd6: v = s.buf6;
         3'd7: v = s.buf7;
      endcase
      return v;
   endfunction

   // ------------------------------------------------------------
   // check generators: receive path and transmit path
   // ------------------------------------------------------------
   rtu_crc u_rx_crc (
      .crc_in  (r.crc),
      .data    (RX_DATA),
      .crc_out (crc_next)
   );
   rtu_crc u_tx_crc (
      .crc_in  (r.tcrc),
      .data    (tx_byte),
      .crc_out (tx_crc_next)
   );

   // read data storage: 12 words kept as byte pairs
   logic [15:0] words [0:11];
   always_ff @(posedge CLOCK or negedge RESETN) begin
      if (!RESETN) begin
         for (int i = 0; i < 12; i++) words[i] <= 16'h0000;
      end else if (r.st == S_ACCES && REQ_ACK && !r.req_write) begin
         words[r.widx[3:0]] <= REQ_RDATA;
      end
   end

   // ------------------------------------------------------------
   // reply byte selection
   // ------------------------------------------------------------
   logic [15:0] cnt_w;
   logic [5:0]  hdr_len, body_len;
   logic [15:0] byte_cnt;
   logic [5:0]  di;
   logic [15:0] wsel;
   always_comb begin
      cnt_w    = {r.buf4, r.buf5};
      byte_cnt = {cnt_w[14:0], 1'b0};
      hdr_len  = REPLY_COUNT_WIDTH_SELECT ? 6'd3 : 6'd4;
      if (r.exc)
         body_len = 6'd3;
      else if (r.buf1 == CMD_WRITE)
         body_len = 6'd6;
      else
         body_len = hdr_len + 6'(byte_cnt);
      di   = r.tidx - hdr_len;
      wsel = words[di[4:1]];
      tx_byte = 8'h00;
      if (r.exc) begin
         unique case (r.tidx)
            6'd0:    tx_byte = r.buf0;
            6'd1:    tx_byte = r.buf1 | EXC_FLAG;
            default: tx_byte = r.exc_code;
         endcase
      end else if (r.buf1 == CMD_WRITE) begin
         tx_byte = pick(r, r.tidx[2:0]);
      end else if (r.tidx == 6'd0) begin
         tx_byte = r.buf0;
      end else if (r.tidx == 6'd1) begin
         tx_byte = r.buf1;
      end else if (r.tidx == 6'd2) begin
         tx_byte = REPLY_COUNT_WIDTH_SELECT ? byte_cnt[7:0] : byte_cnt[15:8];
      end else if (r.tidx == 6'd3 && !REPLY_COUNT_WIDTH_SELECT) begin
         tx_byte = byte_cnt[7:0];
      end else begin
         tx_byte = di[0] ? wsel[7:0] : wsel[15:8];                 // high first
      end
   end

   // ------------------------------------------------------------
   // frame state
   // ------------------------------------------------------------
   logic addr_ok;
   always_comb begin
      next_r  = r;
      addr_ok = (r.buf0 == ADDR_BCAST) ||
                (r.buf0 == STATION_ADDR && STATION_ADDR <= ADDR_MAX);
      next_r.chk_err = 1'b0;
      if (r.idle != TIMER_MAX) next_r.idle = r.idle + 32'd1;
      if (RX_VALID) next_r.idle = 32'd0;
      unique case (r.st)
         // silence must exceed 3.5 characters before a frame is accepted
         S_IDLE: begin
            if (r.idle >= 32'(END_CYC)) next_r.synced = 1'b1;
            if (RX_VALID && r.synced) begin
               next_r.st     = S_RECV;
               next_r.crc    = crc_next;  // preset folded in below
               next_r.len    = 4'd1;
               next_r.buf0   = RX_DATA;
               next_r.broken = 1'b0;
            end else if (RX_VALID) begin
               next_r.synced = 1'b0;       // chatter restarts the silence wait
            end
         end
         S_RECV: begin
            if (RX_VALID) begin
               // bytes after 1.5 but before 3.5 spoil the frame
               if (r.idle >= 32'(ABORT_CYC)) next_r.broken = 1'b1;
               next_r.crc = crc_next;
               if (r.len != 4'hF) next_r.len = r.len + 4'd1;
               unique case (r.len)
                  4'd1: next_r.buf1 = RX_DATA;
                  4'd2: next_r.buf2 = RX_DATA;
                  4'd3: next_r.buf3 = RX_DATA;
                  4'd4: next_r.buf4 = RX_DATA;
                  4'd5: next_r.buf5 = RX_DATA;
                  4'd6: next_r.buf6 = RX_DATA;
                  4'd7: next_r.buf7 = RX_DATA;
                  default: ;
               endcase
            end else if (r.idle >= 32'(END_CYC)) begin
               next_r.st = S_DONE;
            end
         end
         // over the whole frame incl. check field a good frame leaves zero
         S_DONE: begin
            next_r.st     = S_IDLE;
            next_r.synced = 1'b1;
            next_r.bcast  = (r.buf0 == ADDR_BCAST);
            next_r.exc    = 1'b0;
            next_r.widx   = 5'd0;
            next_r.tidx   = 6'd0;
            next_r.tcrc   = CRC_INIT;
            if (r.len != REQ_LEN || r.broken || r.crc != 16'h0000) begin
               next_r.chk_err = addr_ok;
            end else if (addr_ok) begin
               if (r.buf1 != CMD_READ && r.buf1 != CMD_WRITE) begin
                  next_r.exc = 1'b1; next_r.exc_code = EXC_ILL_FUNC;
                  next_r.st  = (r.buf0 == ADDR_BCAST) ? S_IDLE : S_GAP;
               end else if (r.buf1 == CMD_READ &&
                            ({r.buf4, r.buf5} == 16'h0000 ||
                             {r.buf4, r.buf5} > READ_MAX)) begin
                  next_r.exc = 1'b1; next_r.exc_code = EXC_ILL_DATA;
                  next_r.st  = (r.buf0 == ADDR_BCAST) ? S_IDLE : S_GAP;
               end else begin
                  next_r.st        = S_ACCES;
                  next_r.req_valid = 1'b1;
                  next_r.req_write = (r.buf1 == CMD_WRITE);
                  next_r.req_addr  = {r.buf2, r.buf3};
                  next_r.req_wdata = {r.buf4, r.buf5};
               end
            end
         end
         S_ACCES: begin
            if (REQ_ACK) begin
               next_r.req_valid = 1'b0;
               if (REQ_FAIL) begin
                  next_r.exc = 1'b1; next_r.exc_code = EXC_DEV_FAIL;
                  next_r.st  = r.bcast ? S_IDLE : S_GAP;
               end else if (!r.req_write &&
                            r.widx + 5'd1 < 5'({r.buf4, r.buf5})) begin
                  next_r.widx      = r.widx + 5'd1;
                  next_r.req_addr  = r.req_addr + 16'd1;
                  next_r.req_valid = 1'b1;
               end else begin
                  next_r.st = r.bcast ? S_IDLE : S_GAP;
               end
            end
         end
         // keep a full 3.5 character silence before answering
         S_GAP: begin
            if (RX_VALID) begin
               next_r.st = S_IDLE; next_r.synced = 1'b0;           // line busy, drop reply
            end else if (r.idle >= 32'(END_CYC)) begin
               next_r.st       = S_SEND;
               next_r.tx_en    = 1'b1;
               next_r.tx_valid = 1'b1;
               next_r.tx_data  = tx_byte;
            end
         end
         S_SEND: begin
            if (TX_READY) begin
               next_r.tidx = r.tidx + 6'd1;
               if (r.tidx < body_len) next_r.tcrc = tx_crc_next;
               if (r.tidx + 6'd1 < body_len) begin
                  next_r.tx_data = tx_next_byte;
               end else if (r.tidx + 6'd1 == body_len) begin
                  next_r.tx_data = tx_crc_next[7:0];
               end else if (r.tidx == body_len) begin
                  next_r.tx_data = r.tcrc[15:8];
               end else begin
                  next_r.tx_valid = 1'b0;
                  next_r.tx_en    = 1'b0;
                  next_r.st       = S_IDLE;
                  next_r.synced   = 1'b0;
                  next_r.idle     = 32'd0;
               end
            end
         end
         default: next_r.st = S_IDLE;
      endcase
      // preset outside a frame, so the first byte of a frame already folds into FFFF
      if (r.st != S_RECV && next_r.st != S_RECV) next_r.crc = CRC_INIT;
   end

   // byte after the current one; tx_byte is indexed by r.tidx so re-evaluate
   always_comb begin
      logic [5:0]  n;
      logic [5:0]  dn;
      logic [15:0] wn;
      n  = r.tidx + 6'd1;
      dn = n - hdr_len;
      wn = words[dn[4:1]];
      tx_next_byte = 8'h00;
      if (r.exc)
         tx_next_byte = (n == 6'd1) ? (r.buf1 | EXC_FLAG) : r.exc_code;
      else if (r.buf1 == CMD_WRITE)
         tx_next_byte = pick(r, n[2:0]);
      else if (n == 6'd1)
         tx_next_byte = r.buf1;
      else if (n == 6'd2)
         tx_next_byte = REPLY_COUNT_WIDTH_SELECT ? byte_cnt[7:0] : byte_cnt[15:8];
      else if (n == 6'd3 && !REPLY_COUNT_WIDTH_SELECT)
         tx_next_byte = byte_cnt[7:0];
      else
         tx_next_byte = dn[0] ? wn[7:0] : wn[15:8];
   end

   // ------------------------------------------------------------
   // state register; reset presets both check registers
   // ------------------------------------------------------------
   always_ff @(posedge CLOCK or negedge RESETN) begin
      if (!RESETN) begin
         r     <= '0;
         r.crc <= CRC_INIT;
         r.tcrc <= CRC_INIT;
      end else begin
         r <= next_r;
      end
   end

   // outputs straight from flip-flops
   assign TX_DATA     = r.tx_data;
   assign TX_VALID    = r.tx_valid;
   assign TX_ENABLE   = r.tx_en;
   assign REQ_VALID   = r.req_valid;
   assign REQ_WRITE   = r.req_write;
   assign REQ_ADDR    = r.req_addr;
   assign REQ_WDATA   = r.req_wdata;
   assign CHECK_ERROR = r.chk_err;
endmodule

// file: sim/rtu_slave_framer_sva.sv
// checker: port-level timing of the rtu slave framer
`timescale 1ns/1ps
module rtu_framer_checker
   import rtu_pkg::*;
#(
   parameter int BAUD = BAUD_DEFAULT
)(
   input wire logic        CLOCK,
   input wire logic        RESETN,
   input wire logic        RX_VALID,
   input wire logic [7:0]  TX_DATA,
   input wire logic        TX_VALID,
   input wire logic        TX_READY,
   input wire logic        TX_ENABLE,
   input wire logic        REQ_VALID,
   input wire logic [15:0] REQ_ADDR,
   input wire logic        REQ_ACK,
   input wire logic        CHECK_ERROR
);
   // three whole characters: below the end gap, so design rounding cannot trip it
   localparam int QUIET = CLK_HZ / BAUD * BITS_PER_CHAR * 3;
   int   idle;
   logic err_seen;
   default clocking @(posedge CLOCK); endclocking
   default disable iff (!RESETN);
   // cycles since the last byte; a check error is remembered until the next byte
   always_ff @(posedge CLOCK or negedge RESETN) begin
      if (!RESETN) begin
         idle     <= 0;
         err_seen <= 1'b0;
      end else begin
         idle     <= RX_VALID ? 0 : (idle < QUIET ? idle + 1 : idle);
         err_seen <= RX_VALID ? 1'b0 : (CHECK_ERROR | err_seen);
      end
   end
   sequence tx_offer;
      TX_VALID && !TX_READY;
   endsequence
   sequence req_wait;
      REQ_VALID && !REQ_ACK;
   endsequence
   chk_tx_only_enabled: assert property (TX_VALID |-> TX_ENABLE)
      else $error("reply byte offered with driver off");
   chk_tx_byte_held: assert property (tx_offer |=> TX_VALID && $stable(TX_DATA))
      else $error("reply byte dropped before taken");
   chk_req_held: assert property (req_wait |=> REQ_VALID && $stable(REQ_ADDR))
      else $error("access request dropped before ack");
   chk_reply_after_quiet: assert property ($rose(TX_ENABLE) |-> idle >= QUIET)
      else $error("reply began before the end gap");
   chk_req_after_quiet: assert property ($rose(REQ_VALID) |-> idle >= QUIET)
      else $error("access before frame end gap");
   chk_error_one_pulse: assert property (CHECK_ERROR |=> !CHECK_ERROR)
      else $error("check error longer than one cycle");
   chk_error_silent: assert property (err_seen |-> !$rose(TX_ENABLE) && !$rose(REQ_VALID))
      else $error("failed frame was acted on");
   chk_reset_quiet: assert property (disable iff (1'b0)
      !RESETN |-> !TX_ENABLE && !TX_VALID && !REQ_VALID)
      else $error("outputs active in reset");
endmodule

bind rtu_slave_framer rtu_framer_checker #(.BAUD(BAUD)) u_chk (.CLOCK(CLOCK), .RESETN(RESETN),
   .RX_VALID(RX_VALID), .TX_DATA(TX_DATA), .TX_VALID(TX_VALID), .TX_READY(TX_READY),
   .TX_ENABLE(TX_ENABLE), .REQ_VALID(REQ_VALID), .REQ_ADDR(REQ_ADDR), .REQ_ACK(REQ_ACK),
   .CHECK_ERROR(CHECK_ERROR));

// file: sim/rtu_master_model.sv
// model: bus master that sends request frames and takes reply bytes
`timescale 1ns/1ps
module rtu_master_model #(
   parameter int CHAR_CYC = 220
)(
   input  wire logic       clock,
   output logic      [7:0] rx_data,
   output logic            rx_valid,
   input  wire logic [7:0] tx_data,
   input  wire logic       tx_valid,
   output logic            tx_ready,
   output logic      [7:0] got_byte,
   output logic            got_valid
);
   int seed = 1714;
   int busy = 0;
   initial begin
      rx_data   = 8'h00;
      rx_valid  = 1'b0;
      tx_ready  = 1'b0;
      got_byte  = 8'h00;
      got_valid = 1'b0;
   end
   // frame check over data bytes only
   function automatic logic [15:0] crc16(input logic [7:0] b[$]);
      logic [15:0] c;
      c = 16'hFFFF;
      foreach (b[i]) begin
         c = c ^ {8'h00, b[i]};
         for (int k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
      end
      return c;
   endfunction
   // one byte per character time; gap_at inserts a two-character pause
   task automatic send(input logic [7:0] b[$], input int gap_at, input bit bad);
      logic [15:0] c;
      c = crc16(b) ^ {15'h0000, bad};
      b.push_back(c[7:0]);
      b.push_back(c[15:8]);
      foreach (b[i]) begin
         if (i == gap_at) repeat (CHAR_CYC * 2) @(negedge clock);
         @(negedge clock);
         rx_valid = 1'b1;
         rx_data  = b[i];
         @(negedge clock);
         rx_valid = 1'b0;
         rx_data  = ~b[i];
         repeat (CHAR_CYC - 2) @(negedge clock);
      end
   endtask
   always @(posedge clock) begin
      got_valid <= tx_valid && tx_ready;
      got_byte  <= tx_data;
   end
   // slow taker: busy half a character after each byte, then random stalls
   always @(negedge clock) begin
      if (got_valid) busy = CHAR_CYC / 2;
      else if (busy > 0) busy--;
      tx_ready = (busy == 0) && !got_valid && ($random(seed) & 1);
   end
endmodule

// file: sim/tb_rtu_slave_framer.sv
// testbench: model master requests, replies and accesses compared with notes
`timescale 1ns/1ps
module tb_rtu_slave_framer
   import rtu_pkg::*;
;
   // high baud keeps the gaps short
   localparam int BAUD = 2_000_000;
   localparam int CHR  = CLK_HZ / BAUD * BITS_PER_CHAR;
   logic        clock = 1'b0, resetn, sel = 1'b0, ack = 1'b0, fail = 1'b0;
   logic        fail_next = 1'b0;
   logic [7:0]  station = 8'h01, rx_data, tx_data, got_byte;
   logic [15:0] rdata = 16'h0000, req_addr, req_wdata, salt, a, v;
   logic        rx_valid, tx_valid, tx_ready, tx_enable, req_valid, req_write;
   logic        check_error, got_valid;
   logic [7:0]  exp_q[$];
   logic [32:0] req_q[$];
   logic [32:0] e;
   int          errors = 0, tests_run = 0, seed = 1714, cerr = 0, c0;

   rtu_slave_framer #(.BAUD(BAUD)) uut (.CLOCK(clock), .RESETN(resetn), .STATION_ADDR(station),
      .REPLY_COUNT_WIDTH_SELECT(sel), .RX_DATA(rx_data), .RX_VALID(rx_valid), .TX_DATA(tx_data),
      .TX_VALID(tx_valid), .TX_READY(tx_ready), .TX_ENABLE(tx_enable), .REQ_VALID(req_valid),
      .REQ_WRITE(req_write), .REQ_ADDR(req_addr), .REQ_WDATA(req_wdata), .REQ_ACK(ack),
      .REQ_FAIL(fail), .REQ_RDATA(rdata), .CHECK_ERROR(check_error));
   rtu_master_model #(.CHAR_CYC(CHR)) u_master (.clock(clock), .rx_data(rx_data),
      .rx_valid(rx_valid), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
      .got_byte(got_byte), .got_valid(got_valid));

   initial forever #12.5 clock = ~clock;

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         errors++;
         $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
      end
   endtask

   task automatic conclude;
      $display("checks %0d errors %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   // --------------------------------------------------------------
   // watchers: reply bytes against the oldest note, access responder
   // --------------------------------------------------------------
   always @(posedge clock) begin
      if (got_valid === 1'b1) begin
         if (exp_q.size() == 0) check("unexpected reply byte", 1, 0);
         else check("reply byte", got_byte, exp_q.pop_front());
      end
      if (check_error === 1'b1) cerr++;
   end
   // read data is address xor salt so every word of a burst differs
   initial forever begin
      // look mid-cycle, never in the step of the edge that launches the request
      @(negedge clock);
      if (req_valid === 1'b1) begin
         if (req_q.size() == 0) check("unexpected access", 1, 0);
         else begin
            e = req_q.pop_front();
            check("access kind", req_write, e[32]);
            check("access addr", req_addr, e[31:16]);
            if (e[32]) check("write value", req_wdata, e[15:0]);
         end
         repeat ($random(seed) & 3) @(negedge clock);
         @(negedge clock);
         ack = 1'b1;
         fail = fail_next;
         rdata = req_addr ^ salt;
         @(negedge clock);
         ack = 1'b0;
         fail = 1'b0;
         rdata = ~rdata;
      end
   end

   // waits until reply and accesses have died out for six characters
   task automatic settle;
      int idle, n;
      idle = 0;
      n = 0;
      while (idle < CHR * 6 && n < 20000) begin
         @(negedge clock);
         n++;
         idle = (tx_enable || req_valid) ? 0 : idle + 1;
      end
      check("reply complete", exp_q.size(), 0);
      check("accesses done", req_q.size(), 0);
   endtask

   // one request; gap 99 sends the frame twice with no end gap between
   task automatic req(input logic [7:0] adr, input logic [7:0] cmd, input logic [15:0] p,
                      input logic [15:0] q, input int gap, input bit bad, input bit fl);
      logic [7:0]  b[$];
      logic [7:0]  r[$];
      logic [15:0] c, w;
      bit          ok;
      b = '{adr, cmd, p[15:8], p[7:0], q[15:8], q[7:0]};
      ok = (adr == station || adr == ADDR_BCAST) && gap < 0 && !bad;
      fail_next = fl;
      if (cmd == CMD_READ && q >= 1 && q <= READ_MAX) begin
         r = '{adr, cmd};
         if (!sel) r.push_back(8'h00);
         r.push_back(8'(q * 2));
         for (int i = 0; i < q; i++) begin
            w = (p + 16'(i)) ^ salt;
            if (ok) req_q.push_back({1'b0, p + 16'(i), 16'h0000});
            r.push_back(w[15:8]);
            r.push_back(w[7:0]);
         end
      end else if (cmd == CMD_WRITE) begin
         if (ok) req_q.push_back({1'b1, p, q});
         r = b;
         if (fl) r = '{adr, cmd | EXC_FLAG, EXC_DEV_FAIL};
      end else if (cmd == CMD_READ) r = '{adr, cmd | EXC_FLAG, EXC_ILL_DATA};
      else r = '{adr, cmd | EXC_FLAG, EXC_ILL_FUNC};
      if (ok && adr != ADDR_BCAST) begin
         c = u_master.crc16(r);
         r.push_back(c[7:0]);
         r.push_back(c[15:8]);
         foreach (r[i]) exp_q.push_back(r[i]);
      end
      u_master.send(b, gap, bad);
      if (gap == 99) u_master.send(b, -1, 1'b0);
      settle();
   endtask

   initial begin
      // a real falling edge, so the asynchronous reset clears all state before the first clock
      #1 resetn = 1'b0;
      station = 8'((($random(seed) & 32'hFF) % 247) + 1);
      salt = 16'($random(seed));
      a = 16'($random(seed));
      v = 16'($random(seed));
      repeat (8) @(negedge clock);
      resetn = 1'b1;
      repeat (CHR * 4) @(negedge clock);
      req(station, CMD_READ, a, 16'd2, -1, 0, 0);
      sel = 1'b1;
      req(station, CMD_READ, a, 16'd12, -1, 0, 0);
      req(station, CMD_READ, a, 16'd13, -1, 0, 0);
      req(station, CMD_READ, a, 16'd0, -1, 0, 0);
      req(station, CMD_WRITE, a, v, -1, 0, 0);
      req(station, CMD_WRITE, v, a, -1, 0, 1);
      req(ADDR_BCAST, CMD_WRITE, a, v, -1, 0, 0);
      req(8'((station % 247) + 1), CMD_READ, a, 16'd2, -1, 0, 0);
      c0 = cerr;
      req(station, CMD_WRITE, a, v, -1, 1, 0);
      check("check error pulses", cerr - c0, 1);
      req(station, CMD_READ, a, 16'd2, 4, 0, 0);
      req(station, CMD_WRITE, a, v, 99, 0, 0);
      check("error pulses after gaps", cerr - c0, 3);
      req(station, 8'h04, a, v, -1, 0, 0);
      req(station, CMD_WRITE, v, a, -1, 0, 0);
      conclude();
   end

   // watchdog, well beyond the expected run length
   initial begin
      repeat (99000) @(posedge clock);
      errors++;
      conclude();
   end
endmodule
